// *** sbg_pkg.sv ***
// Constants for the transmit validity, user, status and parity bit generator
package sbg_pkg;

   // Register addresses on the control port
   localparam logic [6:0] ADDR_TX_CONTROL        = 7'h1E;
   localparam logic [6:0] ADDR_STATUS_CONTROL    = 7'h1F;
   localparam logic [6:0] ADDR_STATUS_CATEGORY   = 7'h20;
   localparam logic [6:0] ADDR_STATUS_SOURCE_CH  = 7'h21;
   localparam logic [6:0] ADDR_STATUS_RATE_ACC   = 7'h22;
   localparam logic [6:0] ADDR_STATUS_WORD_LEN   = 7'h23;

   // Reset values
   localparam logic [7:0] RST_TX_CONTROL         = 8'h00;
   localparam logic [7:0] RST_STATUS_CONTROL     = 8'h00;
   localparam logic [7:0] RST_STATUS_CATEGORY    = 8'h00;
   localparam logic [7:0] RST_STATUS_SOURCE_CH   = 8'h00;
   localparam logic [7:0] RST_STATUS_RATE_ACC    = 8'h31;
   localparam logic [7:0] RST_STATUS_WORD_LEN    = 8'h0B;
   localparam logic [7:0] RD_UNMAPPED            = 8'h00;

   // Transmit control register layout
   localparam logic [7:0] TX_CONTROL_MASK        = 8'h7F;
   localparam int         SRC_LSB                = 0;
   localparam int         OVERWRITE_BIT          = 2;
   localparam int         THROUGH_BIT            = 3;
   localparam int         VAL_OVR_BIT            = 4;
   localparam int         VAL_SUB0_BIT           = 5;
   localparam int         VAL_SUB1_BIT           = 6;

   // Source select codes
   localparam logic [1:0] SRC_RECEIVER           = 2'h0;
   localparam logic [1:0] SRC_CONVERTER          = 2'h1;
   localparam logic [1:0] SRC_SECONDARY_AIF      = 2'h2;
   localparam logic [1:0] SRC_PRIMARY_AIF        = 2'h3;

   // Source-number and channel-number field positions inside the source/channel register
   localparam int         CHNUM_SUB1_LSB         = 4;
   localparam int         CHNUM_SUB2_LSB         = 6;
   localparam int         SOURCE_NUMBER_FIELD_LSB             = 0;

   // Field positions inside the rate/accuracy and word-length registers
   localparam int         RATE_LSB               = 0;
   localparam int         ACCURACY_LSB           = 4;
   localparam int         MAX_LEN_BIT            = 0;
   localparam int         WORD_LEN_LSB           = 1;
   localparam int         ORIG_RATE_LSB          = 4;

   // Block geometry
   localparam int         STATUS_BITS_USED       = 40;
   localparam logic [7:0] BLOCK_LAST_FRAME       = 8'hBF;
   localparam logic [7:0] FRAME_FIRST            = 8'h00;
   localparam logic [7:0] FRAME_STEP             = 8'h01;
   localparam logic [1:0] CHNUM_UNUSED           = 2'h0;
   localparam logic [1:0] STATUS_ZERO_PAIR       = 2'h0;

endpackage

// *** sbg_status_bit_gen.sv ***
// Validity, user, channel-status and parity bit generator for the frame serializer
// Notes on behaviour
// RULE1 - Validity is zero unless an exception applies
// RULE2 - Receiver source: send recovered validity bit
// RULE3 - Override: per-sub-frame validity from register bits
// RULE4 - User bit zero except receiver source
// RULE5 - Receiver source: send recovered user bit
// RULE6 - One status bit per sub-frame, 192-frame blocks
// RULE7 - Only first 40 status bits are used
// RULE8 - Both channels share status except channel numbers
// RULE9 - Receiver status resent unless overwrite enabled
// RULE10 - Parity bit gives even parity
// RULE11 - Register bits 2:0 drive status bits 2:0
// RULE12 - Emphasis code drives status bits 5:3
// RULE13 - Status mode field drives status bits 7:6
// RULE14 - Category field drives bits 15:8, resets 00h
// RULE15 - Source number drives bits 19:16 unchanged
// RULE16 - Per-sub-frame channel numbers drive bits 23:20
// RULE17 - Sample-rate code drives 27:24, resets 0001
// RULE18 - Clock accuracy drives 29:28, resets 11
// RULE19 - Two-bit transmit source select register field
// RULE20 - Parity covers sub-frame except the preamble
// RULE21 - Overwrite bit 2 picks register status
// RULE22 - Undefined status bits are sent as zero
// RULE23 - Word length, max flag, original rate bits 39:32
`timescale 1ns/1ps

module sbg_status_bit_gen (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        resetn_i,
   // Register port
   input  wire logic        reg_wr_i,
   input  wire logic        reg_rd_i,
   input  wire logic [6:0]  reg_addr_i,
   input  wire logic [7:0]  reg_wdata_i,
   output logic      [7:0]  reg_rdata_o,
   output logic             reg_rvalid_o,
   // Sub-frame request from the serializer
   input  wire logic        sf_req_i,
   input  wire logic        sf_index_i,
   input  wire logic        block_start_i,
   input  wire logic [23:0] sf_audio_i,
   // Bits recovered by the receiver for this sub-frame
   input  wire logic        rx_validity_i,
   input  wire logic        rx_user_i,
   input  wire logic        rx_status_i,
   // Bits handed to the serializer
   output logic             vucp_valid_o,
   output logic             validity_o,
   output logic             user_o,
   output logic             status_o,
   output logic             parity_o,
   output logic      [7:0]  frame_index_o,
   // Static controls for the surrounding transmitter
   output logic      [1:0]  tx_source_select_o,
   output logic             through_mode_o
);

   // Register state
   logic [7:0] tx_control_q,  tx_control_d;
   logic [7:0] st_control_q,  st_control_d;
   logic [7:0] st_category_q, st_category_d;
   logic [7:0] st_src_ch_q,   st_src_ch_d;
   logic [7:0] st_rate_q,     st_rate_d;
   logic [7:0] st_wlen_q,     st_wlen_d;
   logic [7:0] rdata_q,       rdata_d;
   logic       rvalid_q,      rvalid_d;

   // Sub-frame state
   logic [7:0] frame_q,       frame_d;
   logic [7:0] frame_out_q,   frame_out_d;
   logic       vucp_valid_q,  vucp_valid_d;
   logic       validity_q,    validity_d;
   logic       user_q,        user_d;
   logic       status_q,      status_d;
   logic       parity_q,      parity_d;

   // Decoded controls
   logic [1:0] tx_source_select;
   logic       status_overwrite_enable;
   logic       validity_override_enable;
   logic       validity_value_sub0;
   logic       validity_value_sub1;
   logic       from_receiver;
   logic [1:0] channel_number_sub1;
   logic [1:0] channel_number_sub2;
   logic [3:0] sample_rate_code;
   logic [1:0] clock_accuracy_field;
   logic       max_length_flag;
   logic [2:0] word_length_code;
   logic [3:0] original_rate_code;

   // Per-sub-frame status words and selection
   logic [sbg_pkg::STATUS_BITS_USED-1:0] status_common;
   logic [sbg_pkg::STATUS_BITS_USED-1:0] status_word;
   logic [7:0] cur_frame;
   logic       reg_status_bit;

   // Field decode from the transmit control and status registers
   assign tx_source_select         = tx_control_q[sbg_pkg::SRC_LSB +: 2];        // RULE19
   assign status_overwrite_enable  = tx_control_q[sbg_pkg::OVERWRITE_BIT];       // RULE21
   assign validity_override_enable = tx_control_q[sbg_pkg::VAL_OVR_BIT];
   assign validity_value_sub0      = tx_control_q[sbg_pkg::VAL_SUB0_BIT];
   assign validity_value_sub1      = tx_control_q[sbg_pkg::VAL_SUB1_BIT];
   assign from_receiver            = (tx_source_select == sbg_pkg::SRC_RECEIVER);
   assign channel_number_sub1      = st_src_ch_q[sbg_pkg::CHNUM_SUB1_LSB +: 2];
   assign channel_number_sub2      = st_src_ch_q[sbg_pkg::CHNUM_SUB2_LSB +: 2];
   assign sample_rate_code         = st_rate_q[sbg_pkg::RATE_LSB +: 4];
   assign clock_accuracy_field     = st_rate_q[sbg_pkg::ACCURACY_LSB +: 2];
   assign max_length_flag          = st_wlen_q[sbg_pkg::MAX_LEN_BIT];
   assign word_length_code         = st_wlen_q[sbg_pkg::WORD_LEN_LSB +: 3];
   assign original_rate_code       = st_wlen_q[sbg_pkg::ORIG_RATE_LSB +: 4];

   // Register writes and readback; readback is registered to keep data off gates
   always_comb
   begin
      tx_control_d  = tx_control_q;
      st_control_d  = st_control_q;
      st_category_d = st_category_q;
      st_src_ch_d   = st_src_ch_q;
      st_rate_d     = st_rate_q;
      st_wlen_d     = st_wlen_q;
      rdata_d       = rdata_q;
      rvalid_d      = reg_rd_i;
      if (reg_wr_i)
      begin
         case (reg_addr_i)
            sbg_pkg::ADDR_TX_CONTROL:       tx_control_d  = reg_wdata_i & sbg_pkg::TX_CONTROL_MASK;
            sbg_pkg::ADDR_STATUS_CONTROL:   st_control_d  = reg_wdata_i;   // RULE11
            sbg_pkg::ADDR_STATUS_CATEGORY:  st_category_d = reg_wdata_i;   // RULE14
            sbg_pkg::ADDR_STATUS_SOURCE_CH: st_src_ch_d   = reg_wdata_i;   // RULE15
            sbg_pkg::ADDR_STATUS_RATE_ACC:  st_rate_d     = reg_wdata_i;   // RULE17
            sbg_pkg::ADDR_STATUS_WORD_LEN:  st_wlen_d     = reg_wdata_i;   // RULE23
            default:                        tx_control_d  = tx_control_q;
         endcase
      end
      if (reg_rd_i)
      begin
         case (reg_addr_i)
            sbg_pkg::ADDR_TX_CONTROL:       rdata_d = tx_control_q;
            sbg_pkg::ADDR_STATUS_CONTROL:   rdata_d = st_control_q;
            sbg_pkg::ADDR_STATUS_CATEGORY:  rdata_d = st_category_q;
            sbg_pkg::ADDR_STATUS_SOURCE_CH: rdata_d = st_src_ch_q;
            sbg_pkg::ADDR_STATUS_RATE_ACC:  rdata_d = st_rate_q;
            sbg_pkg::ADDR_STATUS_WORD_LEN:  rdata_d = st_wlen_q;
            default:                        rdata_d = sbg_pkg::RD_UNMAPPED;
         endcase
      end
   end

   // Register state flops
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         tx_control_q  <= sbg_pkg::RST_TX_CONTROL;
         st_control_q  <= sbg_pkg::RST_STATUS_CONTROL;
         st_category_q <= sbg_pkg::RST_STATUS_CATEGORY;   // RULE14
         st_src_ch_q   <= sbg_pkg::RST_STATUS_SOURCE_CH;
         st_rate_q     <= sbg_pkg::RST_STATUS_RATE_ACC;   // RULE17
         st_wlen_q     <= sbg_pkg::RST_STATUS_WORD_LEN;
         rdata_q       <= sbg_pkg::RD_UNMAPPED;
         rvalid_q      <= 1'b0;
      end
      else
      begin
         tx_control_q  <= tx_control_d;
         st_control_q  <= st_control_d;
         st_category_q <= st_category_d;
         st_src_ch_q   <= st_src_ch_d;
         st_rate_q     <= st_rate_d;
         st_wlen_q     <= st_wlen_d;
         rdata_q       <= rdata_d;
         rvalid_q      <= rvalid_d;
      end
   end

   // Consumer status word shared by both channels, channel numbers left empty
   always_comb
   begin
      status_common        = '0;                                  // RULE22
      status_common[7:0]   = st_control_q;                        // RULE11 RULE12 RULE13
      status_common[15:8]  = st_category_q;                       // RULE14
      status_common[19:16] = st_src_ch_q[sbg_pkg::SOURCE_NUMBER_FIELD_LSB +: 4];   // RULE15
      status_common[27:24] = sample_rate_code;                    // RULE17
      status_common[29:28] = clock_accuracy_field;                // RULE18
      status_common[32]    = max_length_flag;                     // RULE23
      status_common[35:33] = word_length_code;                    // RULE23
      status_common[39:36] = original_rate_code;                  // RULE23
   end

   // Each sub-frame carries only its own channel number field
   always_comb
   begin
      status_word = status_common;                                // RULE8
      if (!sf_index_i)
      begin
         status_word[21:20] = channel_number_sub1;                // RULE16
         status_word[23:22] = sbg_pkg::STATUS_ZERO_PAIR;
      end
      else
      begin
         status_word[21:20] = sbg_pkg::STATUS_ZERO_PAIR;
         status_word[23:22] = channel_number_sub2;                // RULE16
      end
   end

   // Frame position within the block; block start forces frame zero
   assign cur_frame = block_start_i ? sbg_pkg::FRAME_FIRST : frame_q;   // RULE6

   // Status bit for this frame, zero past the consumer part of the block
   always_comb
   begin
      reg_status_bit = 1'b0;                                      // RULE22
      if (cur_frame < 8'(sbg_pkg::STATUS_BITS_USED))
      begin
         reg_status_bit = status_word[cur_frame[5:0]];            // RULE7
      end
   end

   // Sub-frame bit generation and frame counting
   always_comb
   begin
      frame_d      = frame_q;
      frame_out_d  = frame_out_q;
      vucp_valid_d = 1'b0;
      validity_d   = validity_q;
      user_d       = user_q;
      status_d     = status_q;
      parity_d     = parity_q;
      if (sf_req_i)
      begin
         vucp_valid_d = 1'b1;
         frame_out_d  = cur_frame;
         // Validity: override wins, then receiver, else valid
         if (validity_override_enable)
         begin
            validity_d = sf_index_i ? validity_value_sub1 : validity_value_sub0;   // RULE3
         end
         else if (from_receiver)
         begin
            validity_d = rx_validity_i;                           // RULE2
         end
         else
         begin
            validity_d = 1'b0;                                    // RULE1
         end
         // No user-data generator exists, only pass-through
         user_d = from_receiver ? rx_user_i : 1'b0;               // RULE4 RULE5
         // Overwrite only matters while the receiver is the source
         status_d = (from_receiver && !status_overwrite_enable) ? rx_status_i
                                                                : reg_status_bit;   // RULE9
         // Even parity over aux, audio, V, U and C; preamble excluded
         parity_d = ^{sf_audio_i, validity_d, user_d, status_d};  // RULE10 RULE20
         // Advance the block after the second sub-frame
         if (sf_index_i)
         begin
            frame_d = (cur_frame == sbg_pkg::BLOCK_LAST_FRAME) ? sbg_pkg::FRAME_FIRST
                                                               : cur_frame + sbg_pkg::FRAME_STEP;   // RULE6
         end
         else
         begin
            frame_d = cur_frame;
         end
      end
   end

   // Sub-frame state flops
   always_ff @(posedge clk_i)
   begin
      if (!resetn_i)
      begin
         frame_q      <= sbg_pkg::FRAME_FIRST;
         frame_out_q  <= sbg_pkg::FRAME_FIRST;
         vucp_valid_q <= 1'b0;
         validity_q   <= 1'b0;
         user_q       <= 1'b0;
         status_q     <= 1'b0;
         parity_q     <= 1'b0;
      end
      else
      begin
         frame_q      <= frame_d;
         frame_out_q  <= frame_out_d;
         vucp_valid_q <= vucp_valid_d;
         validity_q   <= validity_d;
         user_q       <= user_d;
         status_q     <= status_d;
         parity_q     <= parity_d;
      end
   end

   // Outputs, all from flops
   assign reg_rdata_o        = rdata_q;
   assign reg_rvalid_o       = rvalid_q;
   assign vucp_valid_o       = vucp_valid_q;
   assign validity_o         = validity_q;
   assign user_o             = user_q;
   assign status_o           = status_q;
   assign parity_o           = parity_q;
   assign frame_index_o      = frame_out_q;
   assign tx_source_select_o = tx_source_select;
   assign through_mode_o     = tx_control_q[sbg_pkg::THROUGH_BIT];

endmodule

// *** sbg_status_bit_gen_monitor.sv ***
// Port assertions for the status bit generator
`timescale 1ns/1ps
module sbg_status_bit_gen_monitor (
   // Clock, reset and register port
   input wire logic        clk_i, resetn_i, reg_wr_i, reg_rd_i, reg_rvalid_o,
   input wire logic [6:0]  reg_addr_i,
   input wire logic [7:0]  reg_wdata_i, reg_rdata_o, frame_index_o,
   // Sub-frame port and exported controls
   input wire logic        sf_req_i, sf_index_i, block_start_i, rx_validity_i, rx_user_i,
   input wire logic        rx_status_i, vucp_valid_o, validity_o, user_o, status_o,
   input wire logic        parity_o, through_mode_o,
   input wire logic [23:0] sf_audio_i,
   input wire logic [1:0]  tx_source_select_o
);
   logic [6:0] ctl_q, ctl_d;
   logic       rx_src, exp_v;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!resetn_i);
   // Shadow of the transmit control; bit 7 is reserved and never kept
   always_comb
      ctl_d = (reg_wr_i && reg_addr_i == sbg_pkg::ADDR_TX_CONTROL) ? reg_wdata_i[6:0] : ctl_q;
   always_ff @(posedge clk_i)
      ctl_q <= resetn_i ? ctl_d : 7'h00;
   // Override outranks the receiver source for validity
   assign rx_src = ctl_q[1:0] == sbg_pkg::SRC_RECEIVER;
   assign exp_v = ctl_q[4] ? ctl_q[sf_index_i ? 6 : 5] : rx_src && rx_validity_i;
   a_answer_one_cycle: assert property (sf_req_i |=> vucp_valid_o)
      else $error("sub-frame answer missing");
   a_answer_only_asked: assert property (!sf_req_i |=> !vucp_valid_o)
      else $error("answer without request");
   a_validity_value: assert property (sf_req_i |=> validity_o == $past(exp_v))
      else $error("validity bit wrong");
   a_user_value: assert property (sf_req_i |=> user_o == $past(rx_src && rx_user_i))
      else $error("user bit wrong");
   a_status_relay: assert property (
      sf_req_i && rx_src && !ctl_q[2] |=> status_o == $past(rx_status_i))
      else $error("relayed status bit wrong");
   a_parity_even: assert property (vucp_valid_o |->
      !(^{$past(sf_audio_i), validity_o, user_o, status_o, parity_o}))
      else $error("odd parity on sub-frame");
   a_block_restart: assert property (sf_req_i && block_start_i |=> frame_index_o == 8'h00)
      else $error("block start did not give frame 0");
   a_frame_advance: assert property (
      sf_req_i && sf_index_i && !block_start_i ##1 sf_req_i && !block_start_i |=>
      frame_index_o == ($past(frame_index_o) == 8'hBF ? 8'h00 : $past(frame_index_o) + 8'h01))
      else $error("frame counter step wrong");
   a_high_bits_zero: assert property (
      vucp_valid_o && frame_index_o >= 8'h28 && !(rx_src && !ctl_q[2]) |-> !status_o)
      else $error("status bit beyond 40 not zero");
   a_select_export: assert property (
      tx_source_select_o == ctl_q[1:0] && through_mode_o == ctl_q[3])
      else $error("exported source select wrong");
   // Main scenarios reached
   c_block_wrap: cover property (vucp_valid_o && frame_index_o == 8'hBF);
   c_override: cover property (sf_req_i && ctl_q[4]);
   c_relay: cover property (sf_req_i && rx_src && !ctl_q[2]);
endmodule

// *** sbg_serializer_model.sv ***
// Behavioural frame serializer and receiver facing the status bit generator
`timescale 1ns/1ps
module sbg_serializer_model (
   // Clock, reset, run control and generator answers
   input  wire logic        clk_i, resetn_i, start_i, vucp_valid_i, validity_i, user_i,
   input  wire logic        status_i, parity_i,
   input  wire logic [8:0]  frames_i,
   input  wire logic [7:0]  frame_index_i,
   // Requests and what was received
   output logic             sf_req_o, sf_index_o, block_start_o,
   output logic      [23:0] sf_audio_o,
   output logic      [39:0] cs0_o, cs1_o,
   output logic      [3:0]  vu_o,
   output logic      [8:0]  par_err_o
);
   logic [9:0]  left_q;
   logic [23:0] aud_q;
   logic        idx_q;
   // Back-to-back requests; audio keeps changing so stale data never matches
   always_ff @(posedge clk_i)
   begin
      block_start_o <= resetn_i && start_i;
      sf_index_o <= resetn_i && !start_i && !sf_index_o;
      sf_audio_o <= resetn_i ? {sf_audio_o[22:0], ^(sf_audio_o & 24'hE10000)} : 24'h5A3C91;
      left_q <= !resetn_i ? 10'h000 : start_i ? {frames_i, 1'b0} : left_q - 10'(left_q != 0);
      sf_req_o <= resetn_i && (start_i || left_q > 10'h001);
      aud_q <= sf_audio_o;
      idx_q <= sf_index_o;
      par_err_o <= (!resetn_i || start_i) ? 9'h000 :
         par_err_o + 9'(vucp_valid_i && parity_i != ^{aud_q, validity_i, user_i, status_i});
      if (vucp_valid_i)
         vu_o[{idx_q, 1'b0} +: 2] <= {user_i, validity_i};
      if (vucp_valid_i && frame_index_i < 8'h28 && idx_q)
         cs1_o[frame_index_i] <= status_i;
      if (vucp_valid_i && frame_index_i < 8'h28 && !idx_q)
         cs0_o[frame_index_i] <= status_i;
   end
endmodule

// *** sbg_status_bit_gen_test.sv ***
// Self-checking bench for the status bit generator
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin err_total++; \
$display("FAIL %s expected %0h seen %0h", nm, ex, got); end end
module sbg_status_bit_gen_test;
   logic        clk_i = 1'b0, resetn_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0, start = 1'b0;
   logic        rx_validity_i = 1'b0, rx_user_i = 1'b1, rx_status_i = 1'b0;
   logic [6:0]  reg_addr_i = 7'h00;
   logic [7:0]  reg_wdata_i = 8'h00;
   logic [8:0]  frames = 9'h000;
   logic        sf_req_i, sf_index_i, block_start_i, vucp_valid_o, validity_o, user_o;
   logic        status_o, parity_o, reg_rvalid_o, through_mode_o;
   logic [1:0]  tx_source_select_o;
   logic [3:0]  vu;
   logic [7:0]  reg_rdata_o, frame_index_o;
   logic [8:0]  par_err;
   logic [23:0] sf_audio_i;
   logic [39:0] cs0, cs1;
   logic [7:0]  r [0:5];
   logic [7:0]  tc [0:5] = '{8'h01, 8'h02, 8'h03, 8'h00, 8'h50, 8'h33};
   logic        tv [0:5] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b1};
   logic [3:0]  te [0:5] = '{4'h0, 4'h0, 4'h0, 4'hF, 4'hE, 4'h1};
   int          err_total = 0, compares = 0, cyc = 0;
   sbg_status_bit_gen u_sbg_status_bit_gen (.*);
   sbg_serializer_model u_sbg_serializer_model (.clk_i(clk_i), .resetn_i(resetn_i),
      .start_i(start), .vucp_valid_i(vucp_valid_o), .validity_i(validity_o), .user_i(user_o),
      .status_i(status_o), .parity_i(parity_o), .frames_i(frames), .frame_index_i(frame_index_o),
      .sf_req_o(sf_req_i), .sf_index_o(sf_index_i), .block_start_o(block_start_i),
      .sf_audio_o(sf_audio_i), .cs0_o(cs0), .cs1_o(cs1), .vu_o(vu), .par_err_o(par_err));
   // Free-running frame clock
   initial
      forever #4 clk_i = ~clk_i;
   // Hang guard, far above the roughly 700 cycles the tests need
   always @(posedge clk_i)
      if (++cyc == 3000) give_verdict(1'b1);
   task automatic give_verdict(input logic hung);
      err_total += int'(hung);
      $display("Comparisons %0d, mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // Strobes rise one edge after the previous task dropped them
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk_i);
      #1 reg_wr_i = 1'b1;
      reg_addr_i = a;
      reg_wdata_i = d;
      @(posedge clk_i);
      #1 reg_wr_i = 1'b0;
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] ex);
      @(posedge clk_i);
      #1 reg_rd_i = 1'b1;
      reg_addr_i = a;
      @(posedge clk_i);
      #1 reg_rd_i = 1'b0;
      `CHK("read valid", 1'b1, reg_rvalid_o)
      `CHK("read data", ex, reg_rdata_o)
   endtask
   task automatic run(input logic [8:0] n);
      @(posedge clk_i);
      #1 start = 1'b1;
      frames = n;
      @(posedge clk_i);
      #1 start = 1'b0;
      for (int k = 0; k < 600 && sf_req_i; k++)
         @(posedge clk_i) #1;
      // Let the model take the answer to the last request
      @(posedge clk_i) #1;
   endtask
   // Register-sourced status word; each sub-frame carries only its own channel number
   function automatic logic [39:0] cs_exp(input logic s);
      return {r[5], 2'h0, r[4][5:0], s ? r[3][7:6] : 2'h0, s ? 2'h0 : r[3][5:4],
              r[3][3:0], r[2], r[1]};
   endfunction
   // Main sequence
   initial
   begin
      repeat (10) @(posedge clk_i);
      #1 resetn_i = 1'b1;
      r = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h31, 8'h0B};
      for (int i = 0; i < 6; i++)
         rd(sbg_pkg::ADDR_TX_CONTROL + 7'(i), r[i]);
      wr(7'h24, 8'hFF);
      rd(7'h24, 8'h00);
      wr(sbg_pkg::ADDR_TX_CONTROL, 8'hFF);
      rd(sbg_pkg::ADDR_TX_CONTROL, 8'h7F);
      `CHK("source select", 2'h3, tx_source_select_o)
      `CHK("through mode", 1'b1, through_mode_o)
      r = '{8'h01, 8'h4D, 8'h5A, 8'h6C, 8'h2E, 8'hD3};
      for (int i = 0; i < 6; i++)
         wr(sbg_pkg::ADDR_TX_CONTROL + 7'(i), r[i]);
      run(9'h0C1);
      `CHK("status sub0", cs_exp(1'b0), cs0)
      `CHK("status sub1", cs_exp(1'b1), cs1)
      `CHK("parity errors", 9'h000, par_err)
      `CHK("wrapped frame", 8'h00, frame_index_o)
      for (int i = 0; i < 6; i++)
      begin
         wr(sbg_pkg::ADDR_TX_CONTROL, tc[i]);
         rx_validity_i = tv[i];
         run(9'h001);
         `CHK("validity and user", te[i], vu)
      end
      rx_status_i = 1'b1;
      wr(sbg_pkg::ADDR_TX_CONTROL, 8'h00);
      run(9'h030);
      `CHK("relayed status", 40'hFF_FFFF_FFFF, cs0)
      wr(sbg_pkg::ADDR_TX_CONTROL, 8'h04);
      run(9'h030);
      `CHK("overwritten status", cs_exp(1'b1), cs1)
      give_verdict(1'b0);
   end
endmodule
bind sbg_status_bit_gen sbg_status_bit_gen_monitor u_sbg_status_bit_gen_monitor (.*);
